// ### rtl/clk_sel_pkg.sv
// Constants for the reference clock source selector.
// Assumes a single 10 MHz system clock domain.
package clk_sel_pkg;
    // System clock period in ns
    localparam int CLK_PERIOD_NS = 100;
    // Reset release delay, in system clock cycles
    localparam int RST_RELEASE_CYCLES = 16;
    // Trim field width and reset value
    localparam int TRIM_W = 10;
    localparam logic [9:0] TRIM_RESET = 10'h000;
    // Source select encodings and reset value
    localparam logic SRC_INTERNAL = 1'b0;
    localparam logic SRC_EXTERNAL = 1'b1;
    localparam logic SRC_RESET = 1'b0;
    // Drive-level and external clock mode reset values
    localparam logic DRIVE_LEVEL_RESET = 1'b0;
    localparam logic EXT_MODE_RESET = 1'b0;
    // Cycles of the target clock that qualify it before a handover
    localparam int QUALIFY_EDGES = 4;
endpackage : clk_sel_pkg

// ### rtl/edge_sync.sv
// Two-flop synchroniser with a registered rising edge detector.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module edge_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic level,
    output logic rise
);
    logic meta;
    logic prev;

    // First flop feeds only the second flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= async_in;
            level <= meta;
        end
    end

    // Edge detect on the stable copy only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
            rise <= 1'b0;
        end else begin
            prev <= level;
            rise <= level & ~prev;
        end
    end
endmodule : edge_sync

// ### rtl/ref_clock_source_select.sv
// Reference clock source selection, oscillator control bits and internal
// reset release. Assumes sys_clk is a free-running 10 MHz clock and that
// both oscillator clocks arrive as asynchronous levels sampled here.
`timescale 1ns/1ns

// How it works
// - After reset the internal oscillator runs and is the chosen source.
// - The source select bit resets to 0, meaning the internal oscillator.
// - Writing 1 to the select bit moves the reference to the external input.
// - The switch between sources produces no glitch or runt pulse.
// - A ten-bit trim field offsets the internal oscillator about 8 MHz.
// - The drive-level bit is 0 after reset.
// - A low reset input puts the whole block into its reset state.
// - The internal reset releases synchronously after a fixed cycle count.
module ref_clock_source_select
    import clk_sel_pkg::*;
#(
    parameter int RELEASE_CYCLES = clk_sel_pkg::RST_RELEASE_CYCLES,
    parameter int QUAL_EDGES = clk_sel_pkg::QUALIFY_EDGES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ref_source_select,
    input wire logic [clk_sel_pkg::TRIM_W-1:0] trim_in,
    input wire logic trim_load,
    input wire logic drive_level_in,
    input wire logic ext_mode_in,
    input wire logic ctrl_load,
    input wire logic int_osc_clk,
    input wire logic osc_in_pin,
    output logic int_osc_enable,
    output logic [clk_sel_pkg::TRIM_W-1:0] osc_trim,
    output logic osc_drive_level_bit,
    output logic ext_clock_mode_bit,
    output logic ref_sel_active,
    output logic switch_busy,
    output logic master_clk,
    output logic int_rst_n
);
    import clk_sel_pkg::*;

    // Counters are 16 and 8 bits wide; refuse what they cannot reach
    if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > 65535 || QUAL_EDGES < 1
        || QUAL_EDGES > 255) begin : g_bad_param
        $error("ref_clock_source_select: bad parameter");
    end

    typedef enum logic [1:0] {
        S_RUN,
        S_QUALIFY,
        S_HANDOVER
    } sw_state_t;

    sw_state_t state;
    logic int_lvl, int_rise, ext_lvl, ext_rise;
    logic target;
    logic [7:0] qual_cnt;
    logic [15:0] rel_cnt;
    logic target_rise;

    ////////////////////////////////////////////////////////////////////////
    // Clock inputs pass two flops before any logic reads them
    edge_sync u_int_sync (
        .clk(sys_clk),
        .nrst(nrst),
        .async_in(int_osc_clk),
        .level(int_lvl),
        .rise(int_rise)
    );

    edge_sync u_ext_sync (
        .clk(sys_clk),
        .nrst(nrst),
        .async_in(osc_in_pin),
        .level(ext_lvl),
        .rise(ext_rise)
    );

    assign target_rise = (target == SRC_EXTERNAL) ? ext_rise : int_rise;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator control bits; all clear or preset by the reset input
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            osc_trim <= TRIM_RESET;
            osc_drive_level_bit <= DRIVE_LEVEL_RESET;
            ext_clock_mode_bit <= EXT_MODE_RESET;
        end else if (ctrl_load) begin
            osc_drive_level_bit <= drive_level_in;
            ext_clock_mode_bit <= ext_mode_in;
            if (trim_load) begin
                osc_trim <= trim_in;
            end
        end else if (trim_load) begin
            osc_trim <= trim_in;
        end
    end

    // Internal oscillator always kept running; it is the boot source
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            int_osc_enable <= 1'b1;
        end else begin
            int_osc_enable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch sequencer: old source stays until the new one shows edges.
    // Relies on software requesting only a stable target.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_RUN;
            ref_sel_active <= SRC_RESET;
            target <= SRC_RESET;
            qual_cnt <= 8'h00;
            switch_busy <= 1'b0;
        end else begin
            unique case (state)
                S_RUN: begin
                    if (ref_source_select != ref_sel_active) begin
                        target <= ref_source_select;
                        qual_cnt <= 8'h00;
                        switch_busy <= 1'b1;
                        state <= S_QUALIFY;
                    end
                end
                S_QUALIFY: begin
                    if (target_rise) begin
                        if (qual_cnt == 8'(QUAL_EDGES - 1)) begin
                            state <= S_HANDOVER;
                        end
                        qual_cnt <= qual_cnt + 8'h01;
                    end
                end
                S_HANDOVER: begin
                    // Swap only with both clocks low and the master already
                    // low a cycle, so no level is shorter than two.
                    if (!int_lvl && !ext_lvl && !master_clk) begin
                        ref_sel_active <= target;
                        switch_busy <= 1'b0;
                        state <= S_RUN;
                    end
                end
            endcase
        end
    end

    // Registered master clock follows the active synchronised source
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            master_clk <= 1'b0;
        end else begin
            master_clk <= (ref_sel_active == SRC_EXTERNAL) ? ext_lvl
                                                           : int_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal reset: held low, released after a fixed count.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rel_cnt <= 16'h0000;
            int_rst_n <= 1'b0;
        end else if (rel_cnt != 16'(RELEASE_CYCLES)) begin
            rel_cnt <= rel_cnt + 16'h0001;
            int_rst_n <= 1'b0;
        end else begin
            int_rst_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [16:0] low_cnt;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 17'h00000;
        end else if (!int_rst_n) begin
            low_cnt <= low_cnt + 17'h00001;
        end
    end

    AST_RELEASE_COUNT: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $rose(int_rst_n) |-> low_cnt == 17'(RELEASE_CYCLES + 1))
        else $error("internal reset released at wrong count");
    AST_RST_STAYS: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        int_rst_n |=> int_rst_n)
        else $error("internal reset reasserted without reset input");
    AST_NO_SILENT_SWITCH: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $changed(ref_sel_active) |-> $past(state) == S_HANDOVER)
        else $error("source changed outside handover");
    // Both clocks and the master level low on the sample before the swap lands
    AST_SWAP_LOW: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $changed(ref_sel_active) |-> !$past(int_lvl) && !$past(ext_lvl)
            && !$past(master_clk))
        else $error("source swapped while a clock was high");
    AST_SWAP_TARGET: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == S_RUN && ref_source_select != ref_sel_active
        |=> switch_busy && target == $past(ref_source_select))
        else $error("switch request not taken");
    AST_BUSY_MATCH: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        switch_busy == (state != S_RUN))
        else $error("busy flag disagrees with sequencer");
    AST_OSC_ON: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        int_osc_enable)
        else $error("internal oscillator disabled");
    AST_DRIVE_HOLD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ctrl_load |=> $stable(osc_drive_level_bit))
        else $error("drive level changed without a load");
    AST_TRIM_LOAD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        trim_load |=> osc_trim == $past(trim_in))
        else $error("trim not loaded");
    AST_FIRST_SRC: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $rose(int_rst_n) |-> ref_sel_active == SRC_INTERNAL
        || $past(switch_busy, 2) || switch_busy || $past(switch_busy))
        else $error("source not internal at release");

    COV_TO_EXT: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(ref_sel_active));
    COV_TO_INT: cover property (@(posedge sys_clk) disable iff (!nrst)
        $fell(ref_sel_active));
    COV_RELEASE: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(int_rst_n));
endmodule : ref_clock_source_select

// ### test/ref_clock_source_select_tb.sv
// Self-checking bench for the reference clock source selector.
// Assumes the clk_sel_pkg package is compiled first; both oscillators are
// modelled here as free slow clocks that can be stopped on demand.
`timescale 1ns/1ns
module ref_clock_source_select_tb;
    import clk_sel_pkg::*;
    // Short release count keeps the reset phases brief
    localparam int REL = 4;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ref_source_select = 1'b0;
    logic [TRIM_W-1:0] trim_in = 10'h000;
    logic trim_load = 1'b0;
    logic drive_level_in = 1'b0;
    logic ext_mode_in = 1'b0;
    logic ctrl_load = 1'b0;
    logic int_osc_clk = 1'b0;
    logic osc_in_pin = 1'b0;
    logic int_run = 1'b1;
    logic ext_run = 1'b1;
    logic int_osc_enable;
    logic [TRIM_W-1:0] osc_trim;
    logic osc_drive_level_bit;
    logic ext_clock_mode_bit;
    logic ref_sel_active;
    logic switch_busy;
    logic master_clk;
    logic int_rst_n;
    int n_fail = 0;
    int cmp_count = 0;
    int run_len = 8;
    logic last_mclk = 1'b0;

    ref_clock_source_select #(
        .RELEASE_CYCLES(REL),
        .QUAL_EDGES(QUALIFY_EDGES)
    ) dut_u (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ref_source_select(ref_source_select),
        .trim_in(trim_in),
        .trim_load(trim_load),
        .drive_level_in(drive_level_in),
        .ext_mode_in(ext_mode_in),
        .ctrl_load(ctrl_load),
        .int_osc_clk(int_osc_clk),
        .osc_in_pin(osc_in_pin),
        .int_osc_enable(int_osc_enable),
        .osc_trim(osc_trim),
        .osc_drive_level_bit(osc_drive_level_bit),
        .ext_clock_mode_bit(ext_clock_mode_bit),
        .ref_sel_active(ref_sel_active),
        .switch_busy(switch_busy),
        .master_clk(master_clk),
        .int_rst_n(int_rst_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clocks; odd half periods keep the oscillators out of step with sys_clk
    always #50 sys_clk = ~sys_clk;
    // Non-blocking so a toggle on a sys_clk edge never races the sampler
    always #530 if (int_run) int_osc_clk <= ~int_osc_clk;
    always #770 if (ext_run) osc_in_pin <= ~osc_in_pin;

    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-bit compare, widened on purpose for the common reporter
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {9'h0, exp}, {9'h0, got});
    endtask : chk1

    // A one-cycle level on master_clk would be a runt pulse
    always @(negedge sys_clk) begin
        if (nrst !== 1'b1) begin
            run_len = 8;
        end else if (master_clk !== last_mclk) begin
            chk1("master_clk level width", 1'b1, run_len >= 2);
            run_len = 1;
        end else if (run_len < 8) begin
            run_len++;
        end
        last_mclk = master_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset, then count edges until the internal reset lets go
    task automatic do_reset();
        int k;
        @(posedge sys_clk);
        nrst <= 1'b0;
        ref_source_select <= SRC_INTERNAL;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("int_osc_enable", 10'h001, {9'h0, int_osc_enable});
        chk1("ref_sel_active", SRC_RESET, ref_sel_active);
        chk("osc_trim", TRIM_RESET, osc_trim);
        chk1("drive", DRIVE_LEVEL_RESET, osc_drive_level_bit);
        chk1("ext_mode", EXT_MODE_RESET, ext_clock_mode_bit);
        chk("int_rst_n", 10'h000, {9'h0, int_rst_n});
        @(posedge sys_clk);
        nrst <= 1'b1;
        k = 0;
        while (k < 50 && int_rst_n !== 1'b1) begin
            @(posedge sys_clk);
            k++;
            @(negedge sys_clk);
        end
        chk("release edge", 10'(REL + 1), k[9:0]);
    endtask : do_reset

    // Strobed load; a later change of trim_in alone must not load
    task automatic load_trim(input logic [9:0] v);
        @(posedge sys_clk);
        trim_in <= v;
        trim_load <= 1'b1;
        @(posedge sys_clk);
        trim_load <= 1'b0;
        trim_in <= ~v;
        @(negedge sys_clk);
        chk("osc_trim", v, osc_trim);
        repeat (2) @(negedge sys_clk);
        chk("osc_trim held", v, osc_trim);
    endtask : load_trim

    task automatic load_ctrl(input logic d, input logic m);
        @(posedge sys_clk);
        drive_level_in <= d;
        ext_mode_in <= m;
        ctrl_load <= 1'b1;
        @(posedge sys_clk);
        ctrl_load <= 1'b0;
        @(negedge sys_clk);
        chk1("drive bit", d, osc_drive_level_bit);
        chk1("mode bit", m, ext_clock_mode_bit);
    endtask : load_ctrl

    // Select held until busy falls; old source stays in use meanwhile
    task automatic do_switch(input logic sel);
        int k;
        @(posedge sys_clk);
        ref_source_select <= sel;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk1("switch_busy", 1'b1, switch_busy);
        chk1("old source kept", ~sel, ref_sel_active);
        k = 0;
        while (k < 300 && switch_busy !== 1'b0) begin
            @(negedge sys_clk);
            k++;
        end
        chk("ref_sel_active", {9'h0, sel}, {9'h0, ref_sel_active});
    endtask : do_switch

    // Toggles of master_clk over 100 cycles, after the sync pipe settles
    task automatic count_toggles(output int n);
        logic prev;
        n = 0;
        repeat (5) @(negedge sys_clk);
        prev = master_clk;
        repeat (100) begin
            @(negedge sys_clk);
            if (master_clk !== prev) n++;
            prev = master_clk;
        end
    endtask : count_toggles

    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; targets are always running before a switch
    initial begin
        int n;
        do_reset();
        load_trim(10'h3ff);
        load_trim(10'h155);
        load_ctrl(1'b1, 1'b1);
        load_ctrl(1'b0, 1'b0);
        do_switch(SRC_EXTERNAL);
        int_run = 1'b0;
        count_toggles(n);
        chk("follows external", 10'h001, {9'h0, n > 5});
        int_run = 1'b1;
        ext_run = 1'b0;
        count_toggles(n);
        chk("external stopped", 10'h000, n[9:0]);
        ext_run = 1'b1;
        do_switch(SRC_INTERNAL);
        ext_run = 1'b0;
        count_toggles(n);
        chk("follows internal", 10'h001, {9'h0, n > 5});
        ext_run = 1'b1;
        load_trim(10'h2aa);
        load_ctrl(1'b1, 1'b1);
        do_switch(SRC_EXTERNAL);
        // Only the device reset is driven; there is no test reset here
        do_reset();
        summarize();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #1_000_000;
        n_fail++;
        summarize();
    end
endmodule : ref_clock_source_select_tb
